/* dovg_pkg.sv */
/*
 * Shared constants and types for the discharge, overvoltage and gate configuration bank.
 * Assumes an 8-bit register port driven by the device's serial protocol engine.
 */
package dovg_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned NUM_REGS = 3;
    localparam int unsigned RAMP_IDX = 0;
    localparam int unsigned OVP_IDX  = 1;
    localparam int unsigned PWR_IDX  = 2;

    localparam logic [7:0] RAMP_DIS_OFS = 8'hD2;
    localparam logic [7:0] OVP_THR_OFS  = 8'hD5;
    localparam logic [7:0] PWR_STG_OFS  = 8'hD6;

    localparam logic [7:0] REG_OFS  [NUM_REGS] = '{8'hD2, 8'hD5, 8'hD6};
    localparam logic [7:0] REG_RST  [NUM_REGS] = '{8'h7A, 8'h3F, 8'h15};
    // writable bits; the rest are unimplemented and read zero
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'h7F, 8'h3F, 8'hFF};
    localparam logic [7:0] RDATA_NONE          = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned ACT_RAMP_BIT = 6;
    localparam int unsigned SLEW_LSB     = 4;
    localparam int unsigned DIS_CUR_LSB  = 2;
    localparam int unsigned DIS_CONV_BIT = 1;
    localparam int unsigned DIS_THR_BIT  = 0;
    localparam int unsigned OVP_LSB      = 0;
    localparam int unsigned OVP_W        = 6;
    localparam int unsigned SYNC_LSB     = 6;
    localparam int unsigned CONST_DT_BIT = 5;
    localparam int unsigned DT_SCALE_BIT = 4;
    localparam int unsigned MIN_DT_LSB   = 2;
    localparam int unsigned MIN_TIME_LSB = 0;

    // ------------------------------------------------------------
    // decode tables
    // ------------------------------------------------------------
    // slew in uV/us: 40000, 20000, 1000, 500
    localparam logic [15:0] SLEW_UV_TBL [4] = '{16'h9C40, 16'h4E20, 16'h03E8, 16'h01F4};
    // discharge current in mA: 25, 50, 75, 75
    localparam logic [6:0]  DIS_MA_TBL  [4] = '{7'h19, 7'h32, 7'h4B, 7'h4B};
    // minimum dead time at 2 MHz in ns: 10, 20, 40, 60
    localparam logic [5:0]  DT_NS_TBL   [4] = '{6'h0A, 6'h14, 6'h28, 6'h3C};
    // min on/off time scale in quarters: 0.75, 1, 1.25, 1.5
    localparam logic [2:0]  MINT_Q4_TBL [4] = '{3'h3, 3'h4, 3'h5, 3'h6};

    // overvoltage limit: 4.0 V + 0.5 V steps to 16 V, then 1 V steps
    localparam logic [15:0] OVP_BASE_MV   = 16'h0FA0;
    localparam logic [15:0] OVP_FINE_MV   = 16'h01F4;
    localparam logic [5:0]  OVP_KNEE_CODE = 6'h18;
    localparam logic [15:0] OVP_KNEE_MV   = 16'h3E80;
    localparam logic [15:0] OVP_COARSE_MV = 16'h03E8;
    localparam logic [15:0] OVP_MAX_MV    = 16'hD6D8;

    typedef enum logic [1:0] {
        SYNC_IN_RISE,
        SYNC_IN_FALL,
        SYNC_OUT_RISE,
        SYNC_OUT_FALL
    } dovg_sync_role_t;

    typedef enum logic {
        DIS_IDLE,
        DIS_RUN
    } dovg_dis_state_t;

endpackage : dovg_pkg

/* dovg_dis_if.sv */
/*
 * Carrier for the discharge selects between the bank and its discharge sequencer.
 * Assumes both ends sit in the same clock domain.
 */
interface dovg_dis_if;
    logic       act_ramp_en;
    logic       conv_sel;
    logic       thr_sel;
    logic       run;

    modport cfg (output act_ramp_en, output conv_sel, output thr_sel, input run);
    modport ctl (input act_ramp_en, input conv_sel, input thr_sel, output run);
endinterface : dovg_dis_if

/* dovg_field_reg.sv */
/*
 * One 8-bit configuration register with a write mask and a reset value.
 * Assumes write strobes are already decoded to this register.
 */
module dovg_field_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] q_o
);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_o <= RST_VAL & WR_MASK;
        end else if (wr_en_i) begin
            // masked bits never store, so they always read back zero
            q_o <= wdata_i & WR_MASK;
        end
    end
endmodule : dovg_field_reg

/* dovg_discharge_seq.sv */
/*
 * Output discharge sequencer: decides when the discharge path runs.
 * Assumes converter enable and forced discharge come from bits held elsewhere.
 */
module dovg_discharge_seq
    import dovg_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    dovg_dis_if.ctl   dis,
    input  wire logic converter_enable_i,
    input  wire logic forced_output_discharge_i,
    input  wire logic ramp_down_req_i,
    input  wire logic output_above_threshold_i
);
    dovg_dis_state_t state_q;
    dovg_dis_state_t state_d;
    logic            req;
    logic            hold;

    always_comb begin
        req = forced_output_discharge_i
            | (dis.conv_sel & ~converter_enable_i)
            | (dis.act_ramp_en & ramp_down_req_i);
        // keep going while the output is still above the stop level
        hold = dis.thr_sel & output_above_threshold_i;
        case (state_q)
            DIS_IDLE: state_d = req ? DIS_RUN : DIS_IDLE;
            DIS_RUN:  state_d = (req | hold) ? DIS_RUN : DIS_IDLE;
            default:  state_d = DIS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= DIS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign dis.run = (state_q == DIS_RUN);
endmodule : dovg_discharge_seq

/* dovg_regs.sv */
/*
 * Discharge, second overvoltage and power stage configuration bank with decoded
 * static outputs to the analog circuits and the discharge sequencer.
 * Assumes the serial protocol engine presents one-cycle read and write strobes
 * with an 8-bit register address, synchronous to clk_i.
 */
// How it works
// - unimplemented bits drop written data and always read back zero
// - active down ramp enable lets discharge pull output down, resets to one
// - two-bit slew select shared by rising and falling changes, resets to three
// - two-bit discharge current select, codes two and three both fast
// - discharge follows converter enable when this select is set, resets one
// - discharge keeps running until output reaches stop threshold, resets zero
// - ramp and discharge register sits at D2 and resets to 7A
// - threshold codes up to 18 step half volt from four volts
// - threshold codes 18 to 3F step one volt up to 55 volts
// - overvoltage threshold register sits at D5 and resets to 3F
// - two-bit sync role: input rising, input falling, output rising, output falling
// - constant dead time bit removes frequency dependence, resets to zero
// - dead time frequency scaling enable about 2 MHz, resets to one
// - minimum dead time select 10, 20, 40 or 60 ns
// - minimum on/off time scale 0.75, 1, 1.25 or 1.5 times
// - power stage register sits at D6 and resets to 15
// - converter enable is an outside bit that turns the stage on
// - outside forced discharge bit starts the discharge directly
module dovg_regs
    import dovg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        converter_enable_i,
    input  wire logic        forced_output_discharge_i,
    input  wire logic        ramp_down_req_i,
    input  wire logic        output_above_threshold_i,
    output logic             active_down_ramp_enable_o,
    output logic      [1:0]  output_slew_select_o,
    output logic      [15:0] slew_uv_per_us_o,
    output logic      [1:0]  discharge_current_select_o,
    output logic      [6:0]  discharge_current_ma_o,
    output logic             discharge_with_converter_select_o,
    output logic             discharge_to_threshold_select_o,
    output logic             discharge_on_o,
    output logic      [5:0]  second_overvoltage_code_o,
    output logic      [15:0] second_overvoltage_limit_mv_o,
    output logic      [1:0]  sync_role_o,
    output logic             sync_drive_o,
    output logic             sync_falling_o,
    output logic             const_dead_time_o,
    output logic             dead_time_scaling_enable_o,
    output logic      [1:0]  minimum_dead_time_select_o,
    output logic      [5:0]  minimum_dead_time_ns_o,
    output logic      [1:0]  min_on_off_time_scale_o,
    output logic      [2:0]  min_on_off_time_q4_o
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic [NUM_REGS-1:0] reg_hit(input logic [7:0] addr);
        logic [NUM_REGS-1:0] hit;
        hit = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            hit[i] = (addr == REG_OFS[i]);
        end
        return hit;
    endfunction : reg_hit

    logic [NUM_REGS-1:0] wr_hit;
    logic [NUM_REGS-1:0] rd_hit;
    logic [7:0]          regs_q [NUM_REGS];
    logic [7:0]          rd_mux;

    assign wr_hit = reg_wr_i ? reg_hit(reg_addr_i) : '0;
    assign rd_hit = reg_hit(reg_addr_i);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
        dovg_field_reg #(
            .RST_VAL (REG_RST[g]),
            .WR_MASK (REG_MASK[g])
        ) u_reg (
            .clk_i   (clk_i),
            .rst_b_i (rst_b_i),
            .wr_en_i (wr_hit[g]),
            .wdata_i (reg_wdata_i),
            .q_o     (regs_q[g])
        );
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = RDATA_NONE;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (rd_hit[i]) begin
                rd_mux = regs_q[i];
            end
        end
    end

    // read data holds until the next read; a same-cycle write shows afterwards
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= RDATA_NONE;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // raw field outputs
    // ------------------------------------------------------------
    assign active_down_ramp_enable_o         = regs_q[RAMP_IDX][ACT_RAMP_BIT];
    assign output_slew_select_o              = regs_q[RAMP_IDX][SLEW_LSB +: 2];
    assign discharge_current_select_o        = regs_q[RAMP_IDX][DIS_CUR_LSB +: 2];
    assign discharge_with_converter_select_o = regs_q[RAMP_IDX][DIS_CONV_BIT];
    assign discharge_to_threshold_select_o   = regs_q[RAMP_IDX][DIS_THR_BIT];
    assign second_overvoltage_code_o         = regs_q[OVP_IDX][OVP_LSB +: OVP_W];
    assign sync_role_o                       = regs_q[PWR_IDX][SYNC_LSB +: 2];
    assign sync_drive_o                      = regs_q[PWR_IDX][SYNC_LSB + 1];
    assign sync_falling_o                    = regs_q[PWR_IDX][SYNC_LSB];
    assign const_dead_time_o                 = regs_q[PWR_IDX][CONST_DT_BIT];
    assign dead_time_scaling_enable_o        = regs_q[PWR_IDX][DT_SCALE_BIT];
    assign minimum_dead_time_select_o        = regs_q[PWR_IDX][MIN_DT_LSB +: 2];
    assign min_on_off_time_scale_o           = regs_q[PWR_IDX][MIN_TIME_LSB +: 2];

    // ------------------------------------------------------------
    // decoded values, one flop behind the field
    // ------------------------------------------------------------
    logic [15:0] ovp_mv_d;
    logic [5:0]  ovp_code;

    always_comb begin
        ovp_code = second_overvoltage_code_o;
        if (ovp_code <= OVP_KNEE_CODE) begin
            ovp_mv_d = 16'(OVP_BASE_MV + 16'(ovp_code) * OVP_FINE_MV);
        end else begin
            ovp_mv_d = 16'(OVP_KNEE_MV
                     + 16'(ovp_code - OVP_KNEE_CODE) * OVP_COARSE_MV);
        end
    end

    // registered so the analog side sees glitch-free words
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            second_overvoltage_limit_mv_o <= OVP_MAX_MV;
        end else begin
            second_overvoltage_limit_mv_o <= ovp_mv_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slew_uv_per_us_o       <= SLEW_UV_TBL[REG_RST[RAMP_IDX][SLEW_LSB +: 2]];
            discharge_current_ma_o <= DIS_MA_TBL[REG_RST[RAMP_IDX][DIS_CUR_LSB +: 2]];
            minimum_dead_time_ns_o <= DT_NS_TBL[REG_RST[PWR_IDX][MIN_DT_LSB +: 2]];
            min_on_off_time_q4_o   <= MINT_Q4_TBL[REG_RST[PWR_IDX][MIN_TIME_LSB +: 2]];
        end else begin
            slew_uv_per_us_o       <= SLEW_UV_TBL[output_slew_select_o];
            discharge_current_ma_o <= DIS_MA_TBL[discharge_current_select_o];
            minimum_dead_time_ns_o <= DT_NS_TBL[minimum_dead_time_select_o];
            min_on_off_time_q4_o   <= MINT_Q4_TBL[min_on_off_time_scale_o];
        end
    end

    // ------------------------------------------------------------
    // discharge sequencer
    // ------------------------------------------------------------
    dovg_dis_if dis_if ();

    assign dis_if.act_ramp_en = active_down_ramp_enable_o;
    assign dis_if.conv_sel    = discharge_with_converter_select_o;
    assign dis_if.thr_sel     = discharge_to_threshold_select_o;
    assign discharge_on_o     = dis_if.run;

    dovg_discharge_seq u_dis (
        .clk_i                     (clk_i),
        .rst_b_i                   (rst_b_i),
        .dis                       (dis_if.ctl),
        .converter_enable_i        (converter_enable_i),
        .forced_output_discharge_i (forced_output_discharge_i),
        .ramp_down_req_i           (ramp_down_req_i),
        .output_above_threshold_i  (output_above_threshold_i)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic seen_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence ramp_write_s;
        reg_wr_i && reg_addr_i == RAMP_DIS_OFS;
    endsequence

    sequence ovp_read_s;
        reg_rd_i && reg_addr_i == OVP_THR_OFS;
    endsequence

    sequence conv_drop_s;
        discharge_with_converter_select_o && !converter_enable_i;
    endsequence

    ramp_reset_val_a: assert property (!seen_q |-> regs_q[RAMP_IDX] == 8'h7A)
        else $error("ramp register reset value wrong");
    ovp_reset_val_a: assert property (!seen_q |-> second_overvoltage_code_o == 6'h3F)
        else $error("overvoltage code reset value wrong");
    pwr_reset_val_a: assert property (!seen_q |-> regs_q[PWR_IDX] == 8'h15)
        else $error("power stage reset value wrong");

    ramp_write_store_a: assert property (
        ramp_write_s |=> regs_q[RAMP_IDX] == ($past(reg_wdata_i) & 8'h7F)
            && !regs_q[RAMP_IDX][7])
        else $error("ramp register write not stored");
    ovp_unimpl_read_a: assert property (ovp_read_s ##1 1'b1 |-> reg_rdata_o[7:6] == 2'h0)
        else $error("unimplemented overvoltage bits read nonzero");
    unmapped_read_a: assert property (
        reg_rd_i && rd_hit == '0 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read returned nonzero");

    ovp_low_map_a: assert property (
        second_overvoltage_code_o == 6'h00 [*2] |-> second_overvoltage_limit_mv_o == 16'h0FA0)
        else $error("lowest overvoltage code not 4 V");
    ovp_top_map_a: assert property (
        second_overvoltage_code_o == 6'h3F [*2] |-> second_overvoltage_limit_mv_o == 16'hD6D8)
        else $error("top overvoltage code not 55 V");
    slew_fast_a: assert property (
        output_slew_select_o == 2'h0 [*2] |-> slew_uv_per_us_o == 16'h9C40)
        else $error("fastest slew not 40 mV/us");
    dead_time_min_a: assert property (
        minimum_dead_time_select_o == 2'h3 [*2] |-> minimum_dead_time_ns_o == 6'h3C)
        else $error("longest dead time not 60 ns");

    sync_out_fall_a: assert property (
        sync_role_o == SYNC_OUT_FALL |-> sync_drive_o && sync_falling_o)
        else $error("sync output falling role decoded wrong");
    conv_discharge_a: assert property (conv_drop_s |=> discharge_on_o)
        else $error("discharge did not follow converter off");
    forced_discharge_a: assert property (forced_output_discharge_i |=> discharge_on_o)
        else $error("forced discharge not started");
    thr_hold_a: assert property (
        discharge_on_o && discharge_to_threshold_select_o && output_above_threshold_i
            |=> discharge_on_o)
        else $error("discharge stopped above threshold");
    dis_stop_a: assert property (
        discharge_on_o && !forced_output_discharge_i
            && !(discharge_with_converter_select_o && !converter_enable_i)
            && !(active_down_ramp_enable_o && ramp_down_req_i)
            && !(discharge_to_threshold_select_o && output_above_threshold_i)
            |=> !discharge_on_o)
        else $error("discharge did not stop");

    sequence ovp_write_s;
        reg_wr_i && reg_addr_i == OVP_THR_OFS;
    endsequence

    sequence pwr_write_s;
        reg_wr_i && reg_addr_i == PWR_STG_OFS;
    endsequence

    ovp_write_store_a: assert property (
        ovp_write_s |=> regs_q[OVP_IDX] == ($past(reg_wdata_i) & 8'h3F))
        else $error("overvoltage register write not stored");
    pwr_write_store_a: assert property (
        pwr_write_s |=> regs_q[PWR_IDX] == $past(reg_wdata_i))
        else $error("power stage register write not stored");
    ramp_read_back_a: assert property (
        reg_rd_i && reg_addr_i == RAMP_DIS_OFS |=> reg_rdata_o == $past(regs_q[RAMP_IDX]))
        else $error("ramp register read back wrong");
    rdata_hold_a: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    cur_fast_a: assert property (
        discharge_current_select_o == 2'h3 [*2] |-> discharge_current_ma_o == 7'h4B)
        else $error("discharge code three not 75 mA");
    min_time_top_a: assert property (
        min_on_off_time_scale_o == 2'h3 [*2] |-> min_on_off_time_q4_o == 3'h6)
        else $error("top on/off time scale not 1.5");
    ovp_knee_map_a: assert property (
        second_overvoltage_code_o == 6'h18 [*2] |-> second_overvoltage_limit_mv_o == 16'h3E80)
        else $error("overvoltage knee code not 16 V");
    ramp_discharge_a: assert property (
        active_down_ramp_enable_o && ramp_down_req_i |=> discharge_on_o)
        else $error("active down ramp did not start discharge");
    sync_in_rise_a: assert property (
        sync_role_o == SYNC_IN_RISE |-> !sync_drive_o && !sync_falling_o)
        else $error("sync input rising role decoded wrong");

endmodule : dovg_regs

/* dovg_host_model.sv */
/*
 * Host model: issues register reads and writes as the serial engine would.
 * Assumes the bank samples strobes on the rising edge of clk_i.
 */
module dovg_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'h0;
        reg_rd_o    = 1'h0;
    end

    // ------------------------------------------------------------
    // one access, driven on the falling edge
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = w;
        reg_rd_o    = r;
        @(posedge clk_i);
        @(negedge clk_i);
        q           = reg_rdata_i;
        reg_wr_o    = 1'h0;
        reg_rd_o    = 1'h0;
        // released bus shows inverted lines so stale values never pass
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : xfer
endmodule : dovg_host_model

/* dovg_regs_tb.sv */
/*
 * Self-checking bench for the configuration bank.
 * Assumes the host model for register traffic; side inputs driven here.
 */
module dovg_regs_tb
    import dovg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dovg_row_t;

    logic clk_i = 1'h0, rst_b_i = 1'h0, converter_enable = 1'h1, force_dis = 1'h0;
    logic ramp_req = 1'h0, above = 1'h0, wr, rd, act, conv_s, thr_s, dis_on;
    logic sdrv, sfall, cdt, scl;
    logic [7:0] addr, wdata, rdata, q;
    logic [1:0] slew, cur, srole, dts, mts;
    logic [15:0] slew_uv, lim;
    logic [6:0] cur_ma;
    logic [5:0] code, dt_ns;
    logic [2:0] q4;
    int bad_count = 0, tests_run = 0;
    logic [15:0] slew_e [4] = '{16'h9C40, 16'h4E20, 16'h03E8, 16'h01F4};
    logic [15:0] cur_e  [4] = '{16'h19, 16'h32, 16'h4B, 16'h4B};
    logic [15:0] dt_e   [4] = '{16'h0A, 16'h14, 16'h28, 16'h3C};
    logic [15:0] q4_e   [4] = '{16'h3, 16'h4, 16'h5, 16'h6};
    dovg_row_t rows [13] = '{
        '{8'hD2, 8'hFF, 8'h7F}, '{8'hD2, 8'h00, 8'h00},
        '{8'hD2, 8'h95, 8'h15}, '{8'hD2, 8'hAE, 8'h2E},
        '{8'hD5, 8'hFF, 8'h3F}, '{8'hD5, 8'h00, 8'h00},
        '{8'hD5, 8'hD8, 8'h18}, '{8'hD5, 8'h19, 8'h19},
        '{8'hD6, 8'h00, 8'h00}, '{8'hD6, 8'hFF, 8'hFF},
        '{8'hD6, 8'h6B, 8'h6B}, '{8'hD6, 8'hB6, 8'hB6},
        '{8'hD6, 8'hC4, 8'hC4}};

    always #5 clk_i = ~clk_i;

    dovg_host_model hm_u (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

    dovg_regs dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .converter_enable_i(converter_enable), .forced_output_discharge_i(force_dis),
        .ramp_down_req_i(ramp_req), .output_above_threshold_i(above),
        .active_down_ramp_enable_o(act), .output_slew_select_o(slew),
        .slew_uv_per_us_o(slew_uv), .discharge_current_select_o(cur),
        .discharge_current_ma_o(cur_ma), .discharge_with_converter_select_o(conv_s),
        .discharge_to_threshold_select_o(thr_s), .discharge_on_o(dis_on),
        .second_overvoltage_code_o(code), .second_overvoltage_limit_mv_o(lim),
        .sync_role_o(srole), .sync_drive_o(sdrv), .sync_falling_o(sfall),
        .const_dead_time_o(cdt), .dead_time_scaling_enable_o(scl),
        .minimum_dead_time_select_o(dts), .minimum_dead_time_ns_o(dt_ns),
        .min_on_off_time_scale_o(mts), .min_on_off_time_q4_o(q4));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] ovp_mv(input logic [5:0] c);
        if (c <= 6'h18) return 16'h0FA0 + 16'h01F4 * c;
        return 16'h3E80 + 16'h03E8 * (c - 6'h18);
    endfunction : ovp_mv

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask : check

    task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
        hm_u.xfer(1'h0, 1'h1, a, 8'h00, q);
        check(q, e);
        if (a == RAMP_DIS_OFS) begin
            check({1'h0, act, slew, cur, conv_s, thr_s}, e);
            check(slew_uv, slew_e[e[5:4]]);
            check(cur_ma, cur_e[e[3:2]]);
        end else if (a == OVP_THR_OFS) begin
            check(code, e[5:0]);
            check(lim, ovp_mv(e[5:0]));
        end else if (a == PWR_STG_OFS) begin
            check({srole, cdt, scl, dts, mts}, e);
            check({sdrv, sfall}, e[7:6]);
            check(dt_ns, dt_e[e[3:2]]);
            check(q4, q4_e[e[1:0]]);
        end
    endtask : check_reg

    // {converter enable, forced, ramp down, above threshold}
    task automatic dis(input logic [3:0] v, input logic e);
        @(negedge clk_i);
        {converter_enable, force_dis, ramp_req, above} = v;
        @(negedge clk_i);
        check(dis_on, e);
    endtask : dis

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // watchdog: run needs about a hundred cycles
    // ------------------------------------------------------------
    initial begin
        #50000;
        bad_count++;
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk_i);
        check(rdata, 8'h00);
        check(lim, 16'hD6D8);
        check(dis_on, 1'h0);
        rst_b_i = 1'h1;
        check_reg(RAMP_DIS_OFS, 8'h7A);
        check_reg(OVP_THR_OFS, 8'h3F);
        check_reg(PWR_STG_OFS, 8'h15);
        $display("test reset done");
        foreach (rows[i]) begin
            hm_u.xfer(1'h1, 1'h0, rows[i].a, rows[i].d, q);
            check_reg(rows[i].a, rows[i].e);
        end
        $display("test table done");
        // unmapped write must not land anywhere
        hm_u.xfer(1'h1, 1'h0, 8'hD3, 8'h55, q);
        check_reg(8'hD3, 8'h00);
        check_reg(RAMP_DIS_OFS, 8'h2E);
        // read and write in one cycle: old value comes back
        hm_u.xfer(1'h1, 1'h1, PWR_STG_OFS, 8'h00, q);
        check(q, 8'hC4);
        check_reg(PWR_STG_OFS, 8'h00);
        $display("test access done");
        hm_u.xfer(1'h1, 1'h0, RAMP_DIS_OFS, 8'h42, q);
        dis(4'h8, 1'h0);
        dis(4'h0, 1'h1);
        dis(4'h8, 1'h0);
        dis(4'hC, 1'h1);
        dis(4'hA, 1'h1);
        dis(4'h9, 1'h0);
        hm_u.xfer(1'h1, 1'h0, RAMP_DIS_OFS, 8'h01, q);
        dis(4'h2, 1'h0);
        dis(4'h0, 1'h0);
        dis(4'h5, 1'h1);
        dis(4'h1, 1'h1);
        dis(4'h0, 1'h0);
        $display("test discharge done");
        // second reset in mid-run restores the power stage value
        @(negedge clk_i);
        rst_b_i = 1'h0;
        @(negedge clk_i);
        rst_b_i = 1'h1;
        check_reg(PWR_STG_OFS, 8'h15);
        check_reg(RAMP_DIS_OFS, 8'h7A);
        $display("test second reset done");
        complete_run();
    end
endmodule : dovg_regs_tb
